// ==== test/adc_sequence_control_bench.sv ====
// self-checking bench for the converter sequencing control block
// assumes the design package, fifo, stream interface and converter model
`timescale 1ns/10ps
module adc_sequence_control_bench;
	import adc_seq_pkg::*;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic go = 1'b0;
	logic [7:0] count = 8'h00;
	logic slow = 1'b0;
	logic full_seen = 1'b0;
	logic [31:0] hrdata, q;
	logic hreadyout, hresp, conv_valid, conv_ready, conv_event;
	logic ref_pos_external, ref_neg_external, scan_active, sample_set_b;
	logic buffer_half_status;
	logic [15:0] conv_data;
	logic [3:0] channel_enable;
	int failures = 0;
	int n_checks = 0;
	int n_ev = 0;
	int sent = 0;
	int rate[4] = '{0, 1, 14, 15};
	int words[4] = '{4, 6, 30, 32};

	always #4 hclk = ~hclk;
	always @(posedge hclk) if (conv_event === 1'b1) n_ev++;
	always @(negedge hclk) if (conv_ready === 1'b0) full_seen = 1'b1;

	adc_sequence_control dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans,
		.hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
		.hresp, .conv_valid, .conv_data, .conv_ready, .ref_pos_external,
		.ref_neg_external, .scan_active, .channel_enable, .sample_set_b,
		.conv_event, .buffer_half_status);
	converter_model model_u (.clk(hclk), .rst_n(hresetn), .go, .count,
		.slow, .ready(conv_ready), .valid(conv_valid), .data(conv_data));

	// ****************************************
	// bus and check tasks
	// ****************************************
	task automatic xfer(input logic w, input logic [31:0] a, d,
		output logic [31:0] r);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		hsize <= HSIZE_WORD;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask : xfer

	task automatic wr(input logic [31:0] a, d);
		logic [31:0] r;
		xfer(1'b1, a, d, r);
		@(posedge hclk);
		#1;
	endtask : wr

	task automatic chk(input string nm, input logic [31:0] seen, exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic send(input int n, input logic s);
		@(posedge hclk);
		go <= 1'b1;
		count <= 8'(n);
		slow <= s;
		@(posedge hclk);
		go <= 1'b0;
		sent += n;
	endtask : send

	// bounded poll: producer done and fifo level back at zero
	task automatic drain;
		int k;
		logic [31:0] r;
		k = 0;
		do begin
			xfer(1'b0, STATUS_OFS, 32'h0, r);
			k++;
		end while ((r[4:0] !== 5'h00 || model_u.left_r !== 8'h00) && k < 200);
		repeat (3) @(posedge hclk);
		#1;
	endtask : drain

	task automatic results;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : results

	// ****************************************
	// tests
	// ****************************************
	initial begin
		#200000;
		failures++;
		results();
	end

	initial begin
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		#1;
		chk("chan_rst", channel_enable, 4'h1);
		xfer(1'b0, CTRL_TWO_OFS, 32'h0, q);
		chk("ctrl_rst", q, 32'h0);
		chk("resp", hresp, 1'b0);
		xfer(1'b0, 32'h3C, 32'h0, q);
		chk("unmapped", q, 32'h0);
		for (int c = 0; c < 8; c++) begin
			wr(CTRL_TWO_OFS, c << REF_LSB);
			chk("ref_ext", {ref_pos_external, ref_neg_external},
				c < 4 ? {c[0], c[1]} : 2'b00);
		end
		for (int c = 0; c < 4; c++) begin
			wr(CTRL_TWO_OFS, c << CHCNT_LSB);
			chk("chan_en", channel_enable,
				c[1] ? 4'hF : (c[0] ? 4'h3 : 4'h1));
		end
		wr(CTRL_ONE_OFS, 32'h1);
		xfer(1'b0, CTRL_TWO_OFS, 32'h0, q);
		chk("cnt_12b", q[9:8], 2'h0);
		chk("chan_12b", channel_enable, 4'h1);
		// count writes are dropped while twelve-bit operation is on
		wr(CTRL_TWO_OFS, 32'h100);
		wr(CTRL_ONE_OFS, 32'h0);
		chk("cnt_kept", channel_enable, 4'hF);
		wr(CTRL_TWO_OFS, 32'h400);
		chk("scan_on", scan_active, 1'b1);
		wr(CTRL_TWO_OFS, 32'h0);
		chk("scan_off", scan_active, 1'b0);
		foreach (rate[i]) begin
			wr(CTRL_TWO_OFS, rate[i] << RATE_LSB);
			n_ev = 0;
			send(words[i], rate[i][0]);
			drain();
			chk("events", n_ev, words[i] / (rate[i] + 1));
		end
		send(2, 1'b0);
		drain();
		xfer(1'b0, 32'h40, 32'h0, q);
		// the first word after the last event lands at 0x0
		chk("buf_lo", q[15:0], 32'hA000 + sent - 2);
		wr(CTRL_TWO_OFS, 32'h2);
		send(1, 1'b0);
		drain();
		chk("half_a", buffer_half_status, 1'b1);
		xfer(1'b0, CTRL_TWO_OFS, 32'h0, q);
		chk("half_rd", q[7], 1'b1);
		send(1, 1'b0);
		drain();
		chk("half_b", buffer_half_status, 1'b0);
		xfer(1'b0, 32'h60, 32'h0, q);
		chk("buf_hi", q[15:0], 32'hA000 + sent - 1);
		wr(CTRL_TWO_OFS, 32'h401);
		chk("set_a", {sample_set_b, scan_active}, 2'b01);
		send(1, 1'b0);
		drain();
		chk("set_b", {sample_set_b, scan_active}, 2'b10);
		send(1, 1'b0);
		drain();
		chk("set_a2", sample_set_b, 1'b0);
		// reads of the buffer hold off the drain, so the fifo backs up
		wr(CTRL_TWO_OFS, 32'h0);
		full_seen = 1'b0;
		// one stalled drain cycle in three: full after some 45 words
		send(64, 1'b0);
		repeat (30) xfer(1'b0, 32'h40, 32'h0, q);
		chk("fifo_full", full_seen, 1'b1);
		drain();
		xfer(1'b0, STATUS_OFS, 32'h0, q);
		chk("fifo_empty", q[4:0], 5'h00);
		results();
	end
endmodule : adc_sequence_control_bench

// ==== test/converter_model.sv ====
// behavioural converter feeding result words to the sequencing block
// assumes one clock; sends count words after a go pulse
`timescale 1ns/10ps
module converter_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic go,
	input wire logic [7:0] count,
	input wire logic slow,
	input wire logic ready,
	output logic valid,
	output logic [adc_seq_pkg::DATA_W-1:0] data
);
	import adc_seq_pkg::*;
	logic [7:0] left_r;
	logic gap_r;
	logic [DATA_W-1:0] val_r;
	assign valid = (left_r != 8'h00) && !gap_r;
	// idle bus shows the inverse of the next word so stale data never matches
	assign data = valid ? val_r : ~val_r;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			left_r <= 8'h00;
			gap_r <= 1'b0;
			val_r <= 16'hA000;
		end else if (go) begin
			left_r <= count;
		end else if (valid && ready) begin
			left_r <= left_r - 8'h01;
			val_r <= val_r + 16'h0001;
			gap_r <= slow;
		end else begin
			gap_r <= 1'b0;
		end
	end
endmodule : converter_model

// ==== verilog/adc_seq_pkg.sv ====
// constants shared by the converter sequencing control block
// assumes a 32-bit single-master bus and a converter core on hclk
package adc_seq_pkg;
	// ****************************************
	// sizes
	// ****************************************
	localparam int DATA_W = 16;
	localparam int FIFO_DEPTH = 16;
	localparam int BUF_DEPTH = 16;
	localparam int PTR_W = 4;
	localparam int LVL_W = 5;

	// ****************************************
	// register map (byte addresses)
	// ****************************************
	localparam logic [7:0] CTRL_TWO_OFS = 8'h00;
	localparam logic [7:0] CTRL_ONE_OFS = 8'h04;
	localparam logic [7:0] STATUS_OFS = 8'h08;
	localparam logic [1:0] BUF_SEL = 2'h1;
	localparam logic [2:0] HSIZE_WORD = 3'h2;

	// ****************************************
	// field positions
	// ****************************************
	localparam int REF_LSB = 13;
	localparam int SCAN_POS = 10;
	localparam int CHCNT_LSB = 8;
	localparam int RATE_LSB = 2;
	localparam int SPLIT_POS = 1;
	localparam int ALT_POS = 0;
	localparam int TWELVE_POS = 0;

	// ****************************************
	// reset values
	// ****************************************
	localparam logic [2:0] REF_RST = 3'h0;
	localparam logic SCAN_RST = 1'b0;
	localparam logic [1:0] CHCNT_RST = 2'h0;
	localparam logic [3:0] RATE_RST = 4'h0;
	localparam logic SPLIT_RST = 1'b0;
	localparam logic ALT_RST = 1'b0;
	localparam logic TWELVE_RST = 1'b0;

	// ****************************************
	// encodings
	// ****************************************
	localparam logic [2:0] REF_EXT_POS = 3'h1;
	localparam logic [2:0] REF_EXT_NEG = 3'h2;
	localparam logic [2:0] REF_EXT_BOTH = 3'h3;
	localparam logic [3:0] CH_ZERO_ONLY = 4'h1;
	localparam logic [3:0] CH_ZERO_ONE = 4'h3;
	localparam logic [3:0] CH_ALL = 4'hF;
	localparam logic [3:0] LOW_BASE = 4'h0;
	localparam logic [3:0] HIGH_BASE = 4'h8;

	typedef enum logic [1:0] {
		FILL_LOW = 2'b01,
		FILL_HIGH = 2'b10
	} fill_state_t;
endpackage : adc_seq_pkg

// ==== verilog/adc_sequence_control.sv ====
// second control register of the converter and its sequencing logic
// assumes an AHB-Lite master on hclk and a converter core on hclk
// limitation: result words reach software only through the bus window
`timescale 1ns/10ps
// Behaviour
// (R1) reference code picks references; 1xx selects supply and ground
// (R2) scan bit set scans channel zero positive inputs during sample set A
// (R3) channel count 00 converts channel zero; higher codes add more channels
// (R4) twelve-bit operation: channel count reads zero, only channel zero runs
// (R5) buffer half status one: filling upper half, software reads lower half
// (R6) rate code 1111 raises the event every 16th conversion, 1110 every 15th
// (R7) split mode alternates fill start 0x0 and 0x8; otherwise always 0x0
// (R8) alternate bit toggles sample sets A and B each sample; else always A
// (R9) rate value N raises the event after every N+1 conversions
module adc_sequence_control (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic conv_valid,
	input wire logic [adc_seq_pkg::DATA_W-1:0] conv_data,
	output logic conv_ready,
	output logic ref_pos_external,
	output logic ref_neg_external,
	output logic scan_active,
	output logic [3:0] channel_enable,
	output logic sample_set_b,
	output logic conv_event,
	output logic buffer_half_status
);
	import adc_seq_pkg::*;

	// ****************************************
	// bus slave
	// ****************************************
	// writes land at the end of the data phase, reads answer in it
	logic wr_pend_r;
	logic [7:0] wr_ofs_r;
	logic [31:0] hrdata_r;
	wire addr_ok = hsel && htrans[1] && hready && (hsize == HSIZE_WORD);
	wire rd_now = addr_ok && !hwrite;
	wire [7:0] ofs = haddr[7:0];
	wire rd_two = rd_now && (ofs == CTRL_TWO_OFS);
	wire rd_buf = rd_now && (ofs[7:6] == BUF_SEL);
	wire wr_two = wr_pend_r && (wr_ofs_r == CTRL_TWO_OFS);
	wire wr_one = wr_pend_r && (wr_ofs_r == CTRL_ONE_OFS);

	// zero wait states, so the master never sees a stretched phase
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = hrdata_r;

	// ****************************************
	// control fields
	// ****************************************
	logic [2:0] ref_r;
	logic scan_r;
	logic [1:0] chcnt_r;
	logic [3:0] rate_r;
	logic split_r;
	logic alt_r;
	logic twelve_r;

	// in twelve-bit mode the count field is unimplemented: writes dropped
	wire [2:0] ref_nxt = wr_two ? hwdata[REF_LSB +: 3] : ref_r;
	wire scan_nxt = wr_two ? hwdata[SCAN_POS] : scan_r;
	wire twelve_nxt = wr_one ? hwdata[TWELVE_POS] : twelve_r;
	wire [1:0] chcnt_nxt = (wr_two && !twelve_r) ?
		hwdata[CHCNT_LSB +: 2] : chcnt_r;
	wire [3:0] rate_nxt = wr_two ? hwdata[RATE_LSB +: 4] : rate_r;
	wire split_nxt = wr_two ? hwdata[SPLIT_POS] : split_r;
	wire alt_nxt = wr_two ? hwdata[ALT_POS] : alt_r;
	wire [1:0] eff_cnt = twelve_r ? 2'h0 : chcnt_r; // see (R4)
	wire [1:0] eff_cnt_nxt = twelve_nxt ? 2'h0 : chcnt_nxt; // see (R4)

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ref_r <= REF_RST;
			scan_r <= SCAN_RST;
			chcnt_r <= CHCNT_RST;
			rate_r <= RATE_RST;
			split_r <= SPLIT_RST;
			alt_r <= ALT_RST;
			twelve_r <= TWELVE_RST;
		end else begin
			ref_r <= ref_nxt;
			scan_r <= scan_nxt;
			chcnt_r <= chcnt_nxt;
			rate_r <= rate_nxt;
			split_r <= split_nxt;
			alt_r <= alt_nxt;
			twelve_r <= twelve_nxt;
		end
	end

	// ****************************************
	// analog side selections
	// ****************************************
	assign ref_pos_external = (ref_r == REF_EXT_POS) ||
		(ref_r == REF_EXT_BOTH); // see (R1)
	assign ref_neg_external = (ref_r == REF_EXT_NEG) ||
		(ref_r == REF_EXT_BOTH); // see (R1)
	assign channel_enable = (eff_cnt == 2'h0) ? CH_ZERO_ONLY :
		(eff_cnt == 2'h1) ? CH_ZERO_ONE : CH_ALL; // see (R3)
	assign scan_active = scan_r && !sample_set_b; // see (R2)

	// ****************************************
	// sample set alternation on accepted samples
	// ****************************************
	logic set_b_r;
	wire accept = conv_valid && conv_ready;
	// a cleared alternate bit forces set A from the next cycle on
	wire set_b_nxt = !alt_r ? 1'b0 :
		accept ? !set_b_r : set_b_r; // see (R8)
	assign sample_set_b = set_b_r;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			set_b_r <= 1'b0;
		else
			set_b_r <= set_b_nxt;
	end

	// ****************************************
	// result path: fifo then result buffer
	// ****************************************
	stream_if #(.W(DATA_W)) in_s ();
	stream_if #(.W(DATA_W)) out_s ();
	logic [LVL_W-1:0] fifo_level;

	assign in_s.valid = conv_valid;
	assign in_s.data = conv_data;
	assign conv_ready = in_s.ready;
	// drain stalls while software reads the buffer, so a read never
	// sees a word that is being overwritten in the same cycle
	assign out_s.ready = !rd_buf;
	wire drain = out_s.valid && out_s.ready;

	result_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk(hclk),
		.rst_n(hresetn),
		.in_s(in_s),
		.out_s(out_s),
		.level(fifo_level)
	);

	// ****************************************
	// event counter and fill pointer
	// ****************************************
	logic [3:0] cnt_r;
	logic [PTR_W-1:0] wptr_r;
	logic evt_r;
	fill_state_t fill_r;
	fill_state_t fill_nxt;
	logic [DATA_W-1:0] buf_r [BUF_DEPTH];

	// a new rate setting restarts the count
	wire evt_now = drain && (cnt_r == rate_r); // see (R6) (R9)
	wire [3:0] cnt_nxt = (evt_now || wr_two) ? 4'h0 :
		drain ? cnt_r + 4'h1 : cnt_r; // see (R9)

	// half status follows this state; it toggles on events in split mode and drops to low once split is off
	always_comb begin
		fill_nxt = fill_r;
		case (fill_r)
			FILL_LOW: begin
				if (evt_now && split_r)
					fill_nxt = FILL_HIGH; // see (R7)
			end
			FILL_HIGH: begin
				if ((evt_now && split_r) || !split_r)
					fill_nxt = FILL_LOW; // see (R7)
			end
			default: fill_nxt = FILL_LOW;
		endcase
	end

	// pointer runs on into the other half only if rate exceeds eight samples
	wire [PTR_W-1:0] wptr_nxt = evt_now ?
		((fill_nxt == FILL_HIGH) ? HIGH_BASE : LOW_BASE) :
		drain ? wptr_r + 4'h1 : wptr_r; // see (R7)

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_r <= 4'h0;
			wptr_r <= LOW_BASE;
			evt_r <= 1'b0;
			fill_r <= FILL_LOW;
		end else begin
			cnt_r <= cnt_nxt;
			wptr_r <= wptr_nxt;
			evt_r <= evt_now;
			fill_r <= fill_nxt;
		end
	end

	assign conv_event = evt_r;
	assign buffer_half_status = (fill_r == FILL_HIGH); // see (R5)

	// words reset to zero so a read before any fill is defined
	for (genvar i = 0; i < BUF_DEPTH; i++) begin : g_buf
		always_ff @(posedge hclk or negedge hresetn) begin
			if (!hresetn)
				buf_r[i] <= '0;
			else if (drain && wptr_r == PTR_W'(i))
				buf_r[i] <= out_s.data;
		end
	end

	// ****************************************
	// read data, control words forwarded from this cycle's write
	// ****************************************
	wire half_nxt = (fill_nxt == FILL_HIGH);
	wire [15:0] two_word = {ref_nxt, 2'h0, scan_nxt, eff_cnt_nxt,
		half_nxt, 1'b0, rate_nxt, split_nxt, alt_nxt};
	wire rd_one = (ofs == CTRL_ONE_OFS);
	wire rd_status = (ofs == STATUS_OFS);
	wire [31:0] one_word = {31'h0, twelve_nxt};
	wire [31:0] status_word = {20'h0, cnt_r, 3'h0, fifo_level};
	wire [31:0] buf_word = {16'h0000, buf_r[ofs[5:2]]};
	wire [31:0] rd_word = rd_two ? {16'h0000, two_word} :
		rd_one ? one_word :
		rd_status ? status_word :
		rd_buf ? buf_word : 32'h0000_0000;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_r <= 1'b0;
			wr_ofs_r <= 8'h00;
			hrdata_r <= 32'h0000_0000;
		end else begin
			if (hready) begin
				wr_pend_r <= addr_ok && hwrite;
				wr_ofs_r <= ofs;
			end
			if (rd_now)
				hrdata_r <= rd_word;
		end
	end

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// drained words since the last event or write of control register two
	logic [4:0] hlp_cnt_r;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			hlp_cnt_r <= 5'h00;
		else if (evt_now || wr_two)
			hlp_cnt_r <= 5'h00;
		else if (drain)
			hlp_cnt_r <= hlp_cnt_r + 5'h01;
	end

	a_ref_fallback: assert property ( // see (R1)
		ref_r[2] |-> !ref_pos_external && !ref_neg_external)
		else $error("reference code 1xx must select supply and ground");
	a_scan_set_a: assert property ( // see (R2)
		scan_r && $rose(sample_set_b) |-> !scan_active)
		else $error("scan active outside sample set A");
	a_chan_count: assert property ( // see (R3)
		!twelve_r && chcnt_r[1] |-> channel_enable == CH_ALL)
		else $error("top channel count must enable four channels");
	a_twelve_read: assert property ( // see (R4)
		rd_two && twelve_r && !wr_pend_r |=> hrdata[9:8] == 2'h0
			&& channel_enable == CH_ZERO_ONLY)
		else $error("channel count visible in twelve-bit mode");
	a_half_toggle: assert property ( // see (R5)
		evt_now && split_r |=> buffer_half_status != $past(buffer_half_status))
		else $error("buffer half status did not flip on event");
	a_event_rate: assert property ( // see (R6) (R9)
		evt_now |-> hlp_cnt_r == {1'b0, rate_r})
		else $error("event not after rate plus one conversions");
	a_event_pulse: assert property ( // see (R6)
		evt_now |=> conv_event ##1 (!conv_event || $past(evt_now)))
		else $error("event output not a one-cycle pulse");
	a_fill_start: assert property ( // see (R7)
		evt_now && !split_r |=> wptr_r == LOW_BASE)
		else $error("fill did not restart at 0x0");
	a_fill_upper: assert property ( // see (R7)
		evt_now && split_r && fill_r == FILL_LOW |=> wptr_r == HIGH_BASE)
		else $error("split fill did not move to 0x8");
	a_alt_toggle: assert property ( // see (R8)
		accept && alt_r |=> sample_set_b != $past(sample_set_b))
		else $error("sample set did not alternate");
	a_alt_off: assert property ( // see (R8)
		!alt_r |=> !sample_set_b)
		else $error("sample set B used with alternation off");

	// ****************************************
	// field decode and restart checks
	// ****************************************
	// these catch a decode that drifts from the register field values
	a_ref_both: assert property ( // see (R1)
		ref_r == REF_EXT_BOTH |-> ref_pos_external && ref_neg_external)
		else $error("code 011 must select both external references");
	a_ref_pos: assert property ( // see (R1)
		ref_r == REF_EXT_POS |-> ref_pos_external && !ref_neg_external)
		else $error("code 001 must select the external positive reference");
	a_scan_off: assert property ( // see (R2)
		!scan_r |-> !scan_active)
		else $error("scan active with the scan bit clear");
	a_set_b_scan: assert property ( // see (R2)
		sample_set_b |-> !scan_active)
		else $error("scan active during sample set B");
	a_chan_zero: assert property ( // see (R3)
		!twelve_r && chcnt_r == 2'h0 |-> channel_enable == CH_ZERO_ONLY)
		else $error("count 00 must convert channel zero only");
	a_chan_pair: assert property ( // see (R3)
		!twelve_r && chcnt_r == 2'h1 |-> channel_enable == CH_ZERO_ONE)
		else $error("count 01 must convert channels zero and one");
	a_twelve_chan: assert property ( // see (R4)
		twelve_r |-> channel_enable == CH_ZERO_ONLY)
		else $error("more than channel zero in twelve-bit mode");
	a_twelve_drop: assert property ( // see (R4)
		wr_two && twelve_r |=> chcnt_r == $past(chcnt_r))
		else $error("channel count written in twelve-bit mode");
	a_split_off: assert property ( // see (R7)
		!split_r |=> !buffer_half_status)
		else $error("upper half filled with split mode off");
	a_count_restart: assert property ( // see (R9)
		wr_two |=> cnt_r == 4'h0)
		else $error("conversion count not restarted by a write");
	a_no_early_event: assert property ( // see (R9)
		drain && cnt_r != rate_r |=> !conv_event)
		else $error("event raised before rate plus one conversions");

	// main scenarios
	c_split_event: cover property (evt_now && split_r);
	c_half_high: cover property (evt_now && split_r && fill_r == FILL_HIGH);
	c_alt_accept: cover property (accept && alt_r ##1 accept);
	c_fifo_full: cover property (conv_valid && !conv_ready);
	c_twelve_on: cover property (wr_one && hwdata[TWELVE_POS]);
endmodule : adc_sequence_control

// ==== verilog/result_fifo.sv ====
// synchronous first-in first-out buffer for conversion results
// assumes one clock; storage in flip-flops, depth a power of two
`timescale 1ns/10ps
module result_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic rst_n,
	stream_if.snk in_s,
	stream_if.src out_s,
	output logic [$clog2(DEPTH):0] level
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL_LVL = (AW+1)'(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_r;
	logic [AW-1:0] rd_ptr_r;
	logic [AW:0] cnt_r;
	wire push = in_s.valid && in_s.ready;
	wire pop = out_s.valid && out_s.ready;

	assign in_s.ready = (cnt_r != FULL_LVL);
	assign out_s.valid = (cnt_r != '0);
	assign out_s.data = mem[rd_ptr_r];
	assign level = cnt_r;

	// ****************************************
	// storage, one write enable per entry
	// ****************************************
	for (genvar i = 0; i < DEPTH; i++) begin : g_ent
		always_ff @(posedge clk) begin
			if (push && wr_ptr_r == AW'(i))
				mem[i] <= in_s.data;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			cnt_r <= '0;
		end else begin
			if (push)
				wr_ptr_r <= wr_ptr_r + 1'b1;
			if (pop)
				rd_ptr_r <= rd_ptr_r + 1'b1;
			if (push && !pop)
				cnt_r <= cnt_r + 1'b1;
			else if (pop && !push)
				cnt_r <= cnt_r - 1'b1;
		end
	end

	a_fifo_no_overrun: assert property (@(posedge clk) disable iff (!rst_n)
		cnt_r <= FULL_LVL)
		else $error("fifo level above depth");
endmodule : result_fifo

// ==== verilog/stream_if.sv ====
// valid/ready word stream from the converter to the fifo and from the fifo to the sequencer
// assumes both ends on one clock
`timescale 1ns/10ps
interface stream_if #(parameter int W = 16);
	logic valid;
	logic ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : stream_if
